// ===== src/adc_ctrl.sv
// converter control: channel decode, trigger, sequencing, compare, registers
`timescale 1ns/1ps
`include "adc_defs.svh"
// Contract
// - channel code selects pin, sensor, bandgap, off
// - reserved codes still convert, result undefined
// - four selectable conversion clock sources
// - alternate clock is external reference clock
// - conversion clock divided by chosen ratio
// - alternate clock keeps running in wait
// - hardware trigger starts on counter match
// - match triggers without counter interrupt enabled
// - trigger works in run, wait, stop
// - only two analog pin enable registers
// - successive approximation resolves twelve result bits
// - unsigned right-justified 12, 10, 8 bits
// - single or continuous; single returns idle
// - optional compare less-than or greater-equal
// - complete flag set, interrupt from flag
// - status write aborts, restarts unless disabled or hardware trigger selected
// - flag cleared by status write or low read
module adc_ctrl (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  addr,               // register address
  input  wire logic [7:0]  wr_data,            // register write data
  input  wire logic        wr_en,              // write strobe
  input  wire logic        rd_en,              // read strobe
  output logic      [7:0]  rd_data,            // read data, cycle after strobe
  input  wire logic        local_async_tick,   // local clock pulse
  input  wire logic        alt_clock_tick,     // external reference clock pulse
  input  wire logic        timer_match,        // counter equals match value
  input  wire logic        comparator_in,      // input at or above trial level
  output logic      [11:0] dac_code,           // trial level to the analog side
  output logic      [11:0] pin_gate,           // selected and enabled pin
  output logic             temp_sel,           // temperature sensor routed
  output logic             bandgap_sel,        // bandgap routed
  output logic      [4:0]  channel_code,       // raw channel code
  output logic             conv_active,        // conversion in progress
  output logic             sample_hold,        // sampling phase
  output logic             irq                 // complete interrupt
);
  adc_pkg::ctrl_state_s q;         // registered state
  adc_pkg::ctrl_state_s d;         // next state
  conv_clk_if           cif ();    // link to clock generator
  logic                 tick;      // conversion clock enable
  logic                 wr_sc1;    // write to status control 1
  logic                 done;      // last bit resolved this cycle
  logic                 cmp_true;  // compare condition met
  logic [11:0]          sar_n;     // search word with new bit
  logic [11:0]          fmt;       // formatted result
  logic [11:0]          bitmask;   // weight of current bit

  // pin channel decode, pins 0 to 11 only
  function automatic logic is_pin(input logic [4:0] ch);
    is_pin = (ch <= `CH_LAST_PIN);
  endfunction

  // result width formatting
  function automatic logic [11:0] fmt_result(input logic [11:0] v, input logic [1:0] m);
    if (m == `MODE_12BIT) begin
      fmt_result = v;
    end else if (m == `MODE_10BIT) begin
      fmt_result = {2'h0, v[11:2]};
    end else begin
      fmt_result = {4'h0, v[11:4]};
    end
  endfunction

  conv_clk_gen u_clk_gen (
    .clock            (clock),
    .reset_n          (reset_n),
    .local_async_tick (local_async_tick),
    .alt_clock_tick   (alt_clock_tick),
    .cif              (cif)
  );

  assign cif.clksel = q.clksel;
  assign cif.div    = q.div;
  assign tick       = cif.tick;

  // next-state logic: trigger, sequencer, register port
  always_comb begin
    d        = q;
    d.rdata  = 8'h00;
    wr_sc1   = wr_en && (addr == `OFF_SC1);
    done     = 1'b0;
    bitmask  = 12'(12'h001 << q.bit_idx);
    sar_n    = comparator_in ? (q.sar | bitmask) : q.sar;
    fmt      = fmt_result(sar_n, q.mode);
    cmp_true = q.acfge ? (fmt >= q.cmp_val) : (fmt < q.cmp_val);

    d.trig_prev = timer_match;
    if (timer_match && !q.trig_prev) begin
      d.trig_pend = 1'b1;
    end

    // sequencer
    case (q.state)
      adc_pkg::ST_IDLE: begin
        if (q.hwtrig && q.trig_pend && tick && q.ch != `CH_DISABLED) begin
          d.state = adc_pkg::ST_SAMPLE;
          if (!(timer_match && !q.trig_prev)) begin
            d.trig_pend = 1'b0;
          end
        end
      end
      adc_pkg::ST_SAMPLE: begin
        if (tick) begin
          d.state   = adc_pkg::ST_CONVERT;
          d.bit_idx = `RES_MSB;
          d.sar     = 12'h000;
          d.dac     = 12'(12'h001 << `RES_MSB);
        end
      end
      adc_pkg::ST_CONVERT: begin
        if (tick) begin
          d.sar = sar_n;
          if (q.bit_idx == 4'h0) begin
            done = 1'b1;
          end else begin
            d.bit_idx = 4'(q.bit_idx - 4'h1);
            d.dac     = sar_n | 12'(12'h001 << 4'(q.bit_idx - 4'h1));
          end
        end
      end
      default: begin
        d.state = adc_pkg::ST_IDLE;
      end
    endcase

    // reads; result low read clears flag
    if (rd_en) begin
      if (addr == `OFF_SC1) begin
        d.rdata = {q.done_flag, q.aien, q.cont, q.ch};
      end else if (addr == `OFF_SC2) begin
        d.rdata = {q.state != adc_pkg::ST_IDLE, q.hwtrig, q.cmp_en, q.acfge, 4'h0};
      end else if (addr == `OFF_RES_HI) begin
        d.rdata = {4'h0, q.result[11:8]};
      end else if (addr == `OFF_RES_LO) begin
        d.rdata = q.result[7:0];
        d.done_flag = 1'b0;
      end else if (addr == `OFF_CMP_HI) begin
        d.rdata = {4'h0, q.cmp_val[11:8]};
      end else if (addr == `OFF_CMP_LO) begin
        d.rdata = q.cmp_val[7:0];
      end else if (addr == `OFF_CFG) begin
        d.rdata = {1'b0, q.div, 1'b0, q.mode, q.clksel};
      end else if (addr == `OFF_PIN1) begin
        d.rdata = q.pin1;
      end else if (addr == `OFF_PIN2) begin
        d.rdata = q.pin2;
      end else begin
        d.rdata = 8'h00;
      end
    end

    // completion; set wins over read clear
    if (done) begin
      d.result = fmt;
      if (!q.cmp_en || cmp_true) begin
        d.done_flag = 1'b1;
      end
      d.state = q.cont ? adc_pkg::ST_SAMPLE : adc_pkg::ST_IDLE;
    end

    // writes
    if (wr_en) begin
      if (addr == `OFF_SC1) begin
        d.aien = wr_data[`SC1_AIEN];
        d.cont = wr_data[`SC1_CONT];
        d.ch   = wr_data[4:0];
        d.done_flag = 1'b0;
        if (wr_data[4:0] == `CH_DISABLED || q.hwtrig) begin
          d.state = adc_pkg::ST_IDLE;
        end else begin
          d.state = adc_pkg::ST_SAMPLE;
        end
      end else if (addr == `OFF_SC2) begin
        d.hwtrig = wr_data[`SC2_HWTRIG];
        d.cmp_en = wr_data[`SC2_CMP_EN];
        d.acfge  = wr_data[`SC2_ACFGE];
      end else if (addr == `OFF_CMP_HI) begin
        d.cmp_val[11:8] = wr_data[3:0];
      end else if (addr == `OFF_CMP_LO) begin
        d.cmp_val[7:0] = wr_data;
      end else if (addr == `OFF_CFG) begin
        d.div    = wr_data[`CFG_DIV_HI:`CFG_DIV_LO];
        d.mode   = wr_data[`CFG_MODE_HI:`CFG_MODE_LO];
        d.clksel = wr_data[1:0];
      end else if (addr == `OFF_PIN1) begin
        d.pin1 = wr_data;
      end else if (addr == `OFF_PIN2) begin
        d.pin2 = wr_data;
      end
    end

    if (is_pin(d.ch) && (d.ch[3] ? d.pin2[d.ch[2:0]] : d.pin1[d.ch[2:0]])) begin
      d.pin_gate = 12'(12'h001 << d.ch[3:0]);
    end else begin
      d.pin_gate = 12'h000;
    end
    d.temp_sel = (d.ch == `CH_TEMP);
    d.bg_sel   = (d.ch == `CH_BANDGAP);
    d.irq      = d.done_flag && d.aien;
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q       <= '0;
      q.ch    <= `CH_DISABLED;
      q.mode  <= `MODE_8BIT;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rd_data      = q.rdata;
  assign dac_code     = q.dac;
  assign pin_gate     = q.pin_gate;
  assign temp_sel     = q.temp_sel;
  assign bandgap_sel  = q.bg_sel;
  assign channel_code = q.ch;
  assign conv_active  = (q.state != adc_pkg::ST_IDLE);
  assign sample_hold  = (q.state == adc_pkg::ST_SAMPLE);
  assign irq          = q.irq;

  // helper: conversion ticks counted per conversion
  logic [4:0] conv_ticks_q;  // ticks seen in the search phase
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_ticks_q <= 5'h00;
    end else if (q.state != adc_pkg::ST_CONVERT) begin
      conv_ticks_q <= 5'h00;
    end else if (tick) begin
      conv_ticks_q <= 5'(conv_ticks_q + 5'h01);
    end
  end

  property p_twelve_bits;
    @(posedge clock) disable iff (!reset_n)
      done |-> (conv_ticks_q == 5'(`RES_BITS - 5'h01));
  endproperty
  a_twelve_bits: assert property (p_twelve_bits) else $error("search did not take twelve steps");

  property p_disable_idle;
    @(posedge clock) disable iff (!reset_n)
      (wr_sc1 && wr_data[4:0] == `CH_DISABLED) |=> !conv_active ##1 !conv_active;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("disabled channel still converting");

  property p_write_restart;
    @(posedge clock) disable iff (!reset_n)
      (wr_sc1 && wr_data[4:0] != `CH_DISABLED && !q.hwtrig) |=> sample_hold && !q.done_flag;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("status write did not restart");

  property p_low_read_clears;
    @(posedge clock) disable iff (!reset_n)
      (rd_en && addr == `OFF_RES_LO && !done && !wr_en) |=> !q.done_flag && !irq;
  endproperty
  a_low_read_clears: assert property (p_low_read_clears) else $error("low result read left flag set");

  property p_single_idle;
    @(posedge clock) disable iff (!reset_n)
      (done && !q.cont && !wr_en) |=> !conv_active;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("single conversion did not return idle");

  property p_eight_bit_format;
    @(posedge clock) disable iff (!reset_n)
      (done && q.mode == `MODE_8BIT && !wr_en) |=> q.result[11:8] == 4'h0;
  endproperty
  a_eight_bit_format: assert property (p_eight_bit_format) else $error("8-bit result not right-justified");

  property p_compare_gate;
    @(posedge clock) disable iff (!reset_n)
      (done && q.cmp_en && !cmp_true && !q.done_flag && !wr_en) |=> !q.done_flag;
  endproperty
  a_compare_gate: assert property (p_compare_gate) else $error("flag set on false compare");

  property p_flag_set;
    @(posedge clock) disable iff (!reset_n)
      (done && !q.cmp_en && !wr_en) |=> q.done_flag ##1 (q.done_flag || $past(rd_en) || $past(wr_en));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion did not set flag");

  property p_hw_start;
    @(posedge clock) disable iff (!reset_n)
      (q.state == adc_pkg::ST_IDLE && q.hwtrig && q.trig_pend && tick && q.ch != `CH_DISABLED && !wr_en)
        |=> sample_hold;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("pending match did not start conversion");

  property p_pin_gate;
    @(posedge clock) disable iff (!reset_n)
      $onehot0(pin_gate) && (pin_gate == 12'h000 || is_pin(channel_code));
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin routing not a single selected pin");

endmodule // adc_ctrl

// ===== src/adc_defs.svh
// constants for the converter control: register offsets, fields, codes
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// register offsets on the plain register port
`define OFF_SC1      8'h00
`define OFF_SC2      8'h04
`define OFF_RES_HI   8'h08
`define OFF_RES_LO   8'h0C
`define OFF_CMP_HI   8'h10
`define OFF_CMP_LO   8'h14
`define OFF_CFG      8'h18
`define OFF_PIN1     8'h1C
`define OFF_PIN2     8'h20

// channel codes
`define CH_LAST_PIN  5'h0B
`define CH_TEMP      5'h1A
`define CH_BANDGAP   5'h1B
`define CH_DISABLED  5'h1F

// conversion clock sources
`define CLKSRC_BUS   2'h0
`define CLKSRC_HALF  2'h1
`define CLKSRC_ALT   2'h2
`define CLKSRC_LOCAL 2'h3

// result width modes
`define MODE_8BIT    2'h0
`define MODE_12BIT   2'h1
`define MODE_10BIT   2'h2

// successive approximation
`define RES_MSB      4'hB
`define RES_BITS     5'h0C

// field positions in sc1, sc2 and cfg
`define SC1_FLAG     7
`define SC1_AIEN     6
`define SC1_CONT     5
`define SC2_ACT      7
`define SC2_HWTRIG   6
`define SC2_CMP_EN   5
`define SC2_ACFGE    4
`define CFG_DIV_HI   6
`define CFG_DIV_LO   5
`define CFG_MODE_HI  3
`define CFG_MODE_LO  2

`endif

// ===== src/adc_pkg.sv
// types shared by the converter control modules
package adc_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_e;

  // whole state of the control module
  typedef struct packed {
    conv_state_e state;
    logic [3:0]  bit_idx;
    logic [11:0] sar;
    logic [11:0] result;
    logic        done_flag;
    logic        aien;
    logic        cont;
    logic [4:0]  ch;
    logic        hwtrig;
    logic        cmp_en;
    logic        acfge;
    logic [11:0] cmp_val;
    logic [1:0]  div;
    logic [1:0]  mode;
    logic [1:0]  clksel;
    logic [7:0]  pin1;
    logic [7:0]  pin2;
    logic        trig_prev;
    logic        trig_pend;
    logic [7:0]  rdata;
    logic        irq;
    logic [11:0] dac;
    logic [11:0] pin_gate;
    logic        temp_sel;
    logic        bg_sel;
  } ctrl_state_s;

  // whole state of the conversion clock generator
  typedef struct packed {
    logic       half;
    logic [2:0] cnt;
    logic       tick;
  } clkgen_state_s;

endpackage

// ===== src/conv_clk_if.sv
// carrier between control and conversion clock generator
`timescale 1ns/1ps
interface conv_clk_if;
  logic [1:0] clksel;  // source choice
  logic [1:0] div;     // divide ratio choice
  logic       tick;    // one-cycle conversion clock enable

  modport gen  (input clksel, input div, output tick);
  modport user (output clksel, output div, input tick);
endinterface

// ===== src/conv_clk_gen.sv
// conversion clock enable: source select and divider
`timescale 1ns/1ps
`include "adc_defs.svh"
module conv_clk_gen (
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   local_async_tick,  // local clock pulse, one cycle
  input  wire logic   alt_clock_tick,    // alternate clock pulse, one cycle
  conv_clk_if.gen     cif
);
  adc_pkg::clkgen_state_s s_q;  // registered state
  adc_pkg::clkgen_state_s s_d;  // next state
  logic                   src;  // selected source pulse
  logic [2:0]             lim;  // divider terminal count

  // source pick and divide; alternate clock never gated by wait
  always_comb begin
    s_d      = s_q;
    s_d.half = ~s_q.half;
    s_d.tick = 1'b0;
    lim      = 3'((4'h1 << cif.div) - 4'h1);
    case (cif.clksel)
      `CLKSRC_BUS:  src = 1'b1;
      `CLKSRC_HALF: src = s_q.half;
      `CLKSRC_ALT:  src = alt_clock_tick;
      default:      src = local_async_tick;
    endcase
    if (src) begin
      if (s_q.cnt >= lim) begin
        s_d.cnt  = 3'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = 3'(s_q.cnt + 3'h1);
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.tick = s_q.tick;

  property p_bus_full_rate;
    @(posedge clock) disable iff (!reset_n)
      (cif.clksel == `CLKSRC_BUS && cif.div == 2'h0) |=> cif.tick;
  endproperty
  a_bus_full_rate: assert property (p_bus_full_rate) else $error("bus clock undivided gave no tick");

  property p_div8_spacing;
    @(posedge clock) disable iff (!reset_n)
      (cif.tick && cif.div == 2'h3 && $past(cif.div) == 2'h3) |-> !$past(cif.tick);
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide by eight ticked twice in a row");

endmodule // conv_clk_gen

// ===== bench/analog_side_model.sv
// partner model: analog input levels and real-time counter match source
`timescale 1ns/1ps
module analog_side_model #(
  parameter int MATCH_MOD = 20,  // counter top and match value, counts 0 to it
  parameter int PRESCALE  = 4    // clocks per counter step
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        counter_en,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] pin_gate,
  input  wire logic        temp_sel,
  input  wire logic        bandgap_sel,
  output logic             comparator_in,
  output logic             timer_match
);
  logic [7:0]  cnt_q;   // counter value
  logic [2:0]  pre_q;   // prescaler phase
  logic        junk_q;  // floating input, toggles
  logic [11:0] level;   // routed analog level
  logic        routed;  // some source routed

  // fixed level for each routed source
  always_comb begin
    level = 12'h000;
    routed = 1'b0;
    for (int n = 0; n < 12; n++) begin
      if (pin_gate[n]) begin
        level = 12'(165 + n * 337);
        routed = 1'b1;
      end
    end
    if (temp_sel) begin
      level = 12'h7C3;
      routed = 1'b1;
    end
    if (bandgap_sel) begin
      level = 12'h3FE;
      routed = 1'b1;
    end
  end
  // unrouted input gives nothing reliable
  assign comparator_in = routed ? (level >= dac_code) : junk_q;

  // counter runs, match held one whole step
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      pre_q <= 3'h0;
      junk_q <= 1'b0;
    end else begin
      junk_q <= ~junk_q;
      if (counter_en) begin
        pre_q <= (pre_q == 3'(PRESCALE - 1)) ? 3'h0 : pre_q + 3'h1;
        if (pre_q == 3'(PRESCALE - 1)) begin
          cnt_q <= (cnt_q == 8'(MATCH_MOD)) ? 8'h00 : cnt_q + 8'h01;
        end
      end
    end
  end
  assign timer_match = counter_en && (cnt_q == 8'(MATCH_MOD));
endmodule // analog_side_model

// ===== bench/adc_channel_trigger_control_test.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_channel_trigger_control_test;
  logic        clock            = 1'b0;
  logic        reset_n          = 1'b0;
  logic [7:0]  addr             = 8'h00;
  logic [7:0]  wr_data          = 8'h00;
  logic        wr_en            = 1'b0;
  logic        rd_en            = 1'b0;
  logic        local_async_tick = 1'b0;
  logic        alt_clock_tick   = 1'b0;
  logic        counter_en       = 1'b0;
  logic [1:0]  alt_div          = 2'h0;
  logic [2:0]  loc_div          = 3'h0;
  logic [7:0]  rd_data;
  logic [11:0] dac_code;
  logic [11:0] pin_gate;
  logic        temp_sel;
  logic        bandgap_sel;
  logic [4:0]  channel_code;
  logic        conv_active;
  logic        sample_hold;
  logic        irq;
  logic        comparator_in;
  logic        timer_match;
  logic [11:0] res;
  logic        prev;
  int          n;
  int          starts;
  int          num_errors       = 0;
  int          cmp_count        = 0;
  logic [7:0]  cfg_tab [5]      = '{8'h04, 8'h25, 8'h06, 8'h47, 8'h64};  // source and divide
  int          pr_tab [5]       = '{1, 4, 3, 20, 8};                     // cycles per tick

  adc_ctrl uut (
    .clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .local_async_tick(local_async_tick),
    .alt_clock_tick(alt_clock_tick), .timer_match(timer_match), .comparator_in(comparator_in),
    .dac_code(dac_code), .pin_gate(pin_gate), .temp_sel(temp_sel), .bandgap_sel(bandgap_sel),
    .channel_code(channel_code), .conv_active(conv_active), .sample_hold(sample_hold), .irq(irq)
  );
  analog_side_model #(.MATCH_MOD(20), .PRESCALE(4)) u_far (
    .clock(clock), .reset_n(reset_n), .counter_en(counter_en), .dac_code(dac_code),
    .pin_gate(pin_gate), .temp_sel(temp_sel), .bandgap_sel(bandgap_sel),
    .comparator_in(comparator_in), .timer_match(timer_match)
  );

  // 20 MHz clock
  always #25 clock = ~clock;

  // alternate ticks from the external reference clock, local ticks slower
  always @(posedge clock) begin
    alt_div <= (alt_div == 2'h2) ? 2'h0 : alt_div + 2'h1;
    loc_div <= (loc_div == 3'h4) ? 3'h0 : loc_div + 3'h1;
    alt_clock_tick <= (alt_div == 2'h2);
    local_async_tick <= (loc_div == 3'h4);
  end

  // expected pin level, same table as the far side
  function automatic logic [11:0] lvl(input int c);
    return 12'(165 + c * 337);
  endfunction

  // report and end the run
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // compare one value
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // one-cycle read, data in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(16'(d), 16'(exp));
  endtask

  // bounded wait for the complete interrupt
  task automatic wait_irq(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 800) begin
      @(posedge clock);
      #1 k++;
    end
    if (k >= 800) begin
      num_errors++;
      test_done();
    end
  endtask

  // start, wait, fetch result (low read clears flag)
  task automatic convert(input logic [7:0] sc1, output logic [11:0] r, output int k);
    logic [7:0] hi;
    logic [7:0] lo;
    wr(`OFF_SC1, sc1);
    wait_irq(k);
    rd(`OFF_RES_HI, hi);
    rd(`OFF_RES_LO, lo);
    r = {hi[3:0], lo};
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    #1 check(16'(channel_code), 16'h1F);
    rdc(`OFF_SC1, 8'h1F);
    rdc(`OFF_CFG, 8'h00);
    wr(8'h24, 8'hFF);
    rdc(8'h24, 8'h00);
    wr(`OFF_PIN1, 8'hFF);
    wr(`OFF_PIN2, 8'h0F);
    wr(`OFF_CFG, 8'h04);
    // every pin channel, 12-bit result
    for (int c = 0; c < 12; c++) begin
      convert(8'h40 | 8'(c), res, n);
      check(16'(pin_gate), 16'(12'h001 << c));
      check(16'(res), 16'(lvl(c)));
      check(16'(dac_code), 16'(lvl(c) | 12'h001));
    end
    rdc(`OFF_SC1, 8'h4B);
    check(16'(irq), 16'h0);
    check(16'(conv_active), 16'h0);
    // buffer taken as enabled before the bandgap pick
    convert(8'h5A, res, n);
    check(16'({temp_sel, bandgap_sel, res}), 16'h27C3);
    convert(8'h5B, res, n);
    check(16'({temp_sel, bandgap_sel, res}), 16'h13FE);
    // 10-bit then 8-bit formatting
    wr(`OFF_CFG, 8'h08);
    convert(8'h45, res, n);
    check(16'(res), 16'(lvl(5) >> 2));
    wr(`OFF_CFG, 8'h00);
    convert(8'h45, res, n);
    check(16'(res), 16'(lvl(5) >> 4));
    // disabled pin and reserved code: converts, nothing routed
    wr(`OFF_PIN2, 8'h00);
    convert(8'h48, res, n);
    check(16'({pin_gate, temp_sel, bandgap_sel}), 16'h0);
    convert(8'h55, res, n);
    check(16'({pin_gate, temp_sel, bandgap_sel}), 16'h0);
    wr(`OFF_PIN2, 8'h0F);
    wr(`OFF_CFG, 8'h04);
    // all ones: no conversion
    wr(`OFF_SC1, 8'h5F);
    repeat (20) @(posedge clock);
    #1 check(16'({conv_active, irq}), 16'h0);
    // abort mid-search restarts the count
    wr(`OFF_SC1, 8'h43);
    #1 check(16'(sample_hold), 16'h1);
    repeat (6) @(posedge clock);
    convert(8'h43, res, n);
    check(16'(n >= 12), 16'h1);
    check(16'(res), 16'(lvl(3)));
    // each source and divide ratio
    // alternate source used only outside stop
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_CFG, cfg_tab[i]);
      convert(8'h41, res, n);
      // first tick lands anywhere within one period of the write
      check(16'(n >= 12 * pr_tab[i] + 1 && n <= 13 * pr_tab[i]), 16'h1);
      check(16'(res), 16'(lvl(1)));
    end
    wr(`OFF_CFG, 8'h04);
    // continuous mode restarts at once, all ones stops it
    convert(8'h63, res, n);
    wait_irq(n);
    check(16'(n <= 18), 16'h1);
    wr(`OFF_SC1, 8'h5F);
    repeat (16) @(posedge clock);
    #1 check(16'({conv_active, irq}), 16'h0);
    // compare at the boundary: ge true, lt false, lt true
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_CMP_HI, 8'h01);
      wr(`OFF_CMP_LO, (i == 2) ? 8'hF7 : 8'hF6);
      wr(`OFF_SC2, (i == 0) ? 8'h30 : 8'h20);
      wr(`OFF_SC1, 8'h41);
      repeat (30) @(posedge clock);
      #1 check(16'(irq), 16'(i != 1));
    end
    wr(`OFF_SC1, 8'h5F);
    #1 check(16'(irq), 16'h0);
    // hardware trigger: wait for match, one start per match
    // low-voltage enables taken as set by software
    wr(`OFF_SC2, 8'h40);
    wr(`OFF_SC1, 8'h42);
    repeat (30) @(posedge clock);
    #1 check(16'(conv_active), 16'h0);
    counter_en <= 1'b1;
    starts = 0;
    prev = 1'b0;
    repeat (200) begin
      @(posedge clock);
      #1 if (conv_active && !prev) starts++;
      prev = conv_active;
    end
    counter_en <= 1'b0;
    check(16'(starts), 16'h2);
    repeat (20) @(posedge clock);
    rd(`OFF_RES_LO, res[7:0]);
    check(16'(res[7:0]), 16'(lvl(2) & 12'h0FF));
    test_done();
  end
endmodule // adc_channel_trigger_control_test
